// File: logic/sap_port.sv
// Purpose: Conversion control and three-state result port of a 16-bit
//          successive-approximation sampling converter
// Assumes: Pins asynchronous to CLK_SYS; comparator decision on COMP_IN
// Notes:   Result path: approximation register, buffer, output latch
//
// Function
// - Chip select and read/convert both low start a conversion; host holds 40ns.
// - A running conversion ignores further start requests until finished.
// - Busy stays low during conversion, rises once output latch holds result.
// - With chip select tied low, read/convert falling starts conversion and hold.
// - Data outputs are high impedance while read/convert is low.
// - Chip select falling with read/convert low drives busy low until done.
// - New result readable when chip select falls again after busy rose.
// - Result is a 16-bit word, straight binary or two's complement.
// - Byte select low gives normal lanes; high puts low byte on upper lanes.
// - Internal timing gives a 7us conversion without external adjustment.
// - Data outputs are high impedance whenever chip select is high.
// - Outputs enabled with chip select low and read/convert high.
// - Approximation register cleared at start, resolved MSB first, then latched.
`timescale 1ns/1ps
module sap_port #(
  parameter logic BIPOLAR = 1'b0
) (
  input  wire logic                          CLK_SYS,
  input  wire logic                          RESET,
  input  wire logic                          CS_N,
  input  wire logic                          READ_CONV_N,
  input  wire logic                          BYTE_SEL,
  input  wire logic                          COMP_IN,
  output logic                               BUSY_N,
  output logic                               HOLD,
  output logic      [sap_pkg::RES_BITS-1:0]  DAC_CODE,
  output logic      [sap_pkg::RES_BITS-1:0]  DATA_OUT,
  output logic      [sap_pkg::RES_BITS-1:0]  DATA_OE
);
  import sap_pkg::*;

  typedef struct packed {
    sap_state_t          st;
    logic [RES_BITS-1:0] approx_result_reg;
    logic [RES_BITS-1:0] mask;
    logic [RES_BITS-1:0] dac;
    logic [TICK_W-1:0]   tick;
    logic                busy_n;
    logic                hold;
    logic [RES_BITS-1:0] word;
    logic [RES_BITS-1:0] dout;
    logic [RES_BITS-1:0] oe;
  } sap_port_t;

  sap_port_t         r_ff;
  sap_port_t         nxt_r;
  logic [SYNC_W-1:0] pins_s;
  logic              cs_s;
  logic              rc_s;
  logic              byte_s;
  logic              comp_s;
  logic              start_req;
  logic              oe_now;
  logic              lat_fire;

  sap_stream_if #(.W(RES_BITS)) cnv_if ();
  sap_stream_if #(.W(RES_BITS)) lat_if ();

  sap_sync #(
    .W       (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .clk  (CLK_SYS),
    .rst  (RESET),
    .din  ({COMP_IN, BYTE_SEL, READ_CONV_N, CS_N}),
    .dout (pins_s)
  );

  sap_buf2 #(
    .DEPTH (BUF_DEPTH),
    .W     (RES_BITS)
  ) u_buf (
    .clk    (CLK_SYS),
    .rst    (RESET),
    .in_if  (cnv_if.sink),
    .out_if (lat_if.source)
  );

  assign cs_s   = pins_s[0];
  assign rc_s   = pins_s[1];
  assign byte_s = pins_s[2];
  assign comp_s = pins_s[3];

  // Chip select and read/convert combined: start is both low as a level
  assign start_req = !cs_s && !rc_s;
  assign oe_now    = !cs_s && rc_s;
  assign lat_fire  = lat_if.valid && lat_if.ready;

  always_comb
  begin
    nxt_r        = r_ff;
    cnv_if.valid = (r_ff.st == SAP_PUSH);
    cnv_if.data  = sap_code(BIPOLAR, r_ff.approx_result_reg);
    // Latch still under a read, except to take a finished conversion
    // read level never blocks busy rise
    lat_if.ready = !oe_now || (r_ff.st == SAP_COMMIT);
    case (r_ff.st)
      SAP_IDLE:
      begin
        if (start_req)
        begin
          nxt_r.st                = SAP_CONV;
          nxt_r.hold              = 1'b1;
          nxt_r.busy_n            = 1'b0;
          nxt_r.approx_result_reg = '0;
          nxt_r.mask              = MSB_MASK;
          nxt_r.tick              = '0;
        end
      end
      SAP_CONV:
      begin
        if (r_ff.tick == BIT_LAST)
        begin
          nxt_r.tick = '0;
          if (comp_s)
            nxt_r.approx_result_reg = r_ff.approx_result_reg | r_ff.mask;
          nxt_r.mask = r_ff.mask >> 1;
          if (r_ff.mask[0])
          begin
            nxt_r.st   = SAP_PUSH;
            nxt_r.hold = 1'b0;
          end
        end
        else
          nxt_r.tick = TICK_W'(r_ff.tick + 1'b1);
      end
      SAP_PUSH:
      begin
        if (cnv_if.ready)
          nxt_r.st = SAP_COMMIT;
      end
      SAP_COMMIT:
      begin
        if (lat_fire)
        begin
          nxt_r.st     = SAP_IDLE;
          nxt_r.busy_n = 1'b1;
        end
      end
      default:
      begin
        nxt_r.st     = SAP_IDLE;
        nxt_r.busy_n = 1'b1;
        nxt_r.hold   = 1'b0;
      end
    endcase
    if (lat_fire)
      nxt_r.word = lat_if.data;
    nxt_r.dout = byte_s ? sap_swap(nxt_r.word) : nxt_r.word;
    nxt_r.oe = {RES_BITS{oe_now}};
    // Trial code for the comparator
    nxt_r.dac = nxt_r.approx_result_reg | nxt_r.mask;
  end

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      r_ff                   <= '0;
      r_ff.st                <= SAP_IDLE;
      r_ff.busy_n            <= 1'b1;
      r_ff.word              <= WORD_RST;
    end
    else
      r_ff <= nxt_r;
  end

  assign BUSY_N   = r_ff.busy_n;
  assign HOLD     = r_ff.hold;
  assign DAC_CODE = r_ff.dac;
  assign DATA_OUT = r_ff.dout;
  assign DATA_OE  = r_ff.oe;

  // Helper: length of each busy-low period, saturating
  localparam int CONV_LAST = BIT_CYC * RES_BITS - 1;
  logic [LOWCNT_W-1:0] low_cnt_ff;

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
      low_cnt_ff <= '0;
    else if (BUSY_N)
      low_cnt_ff <= '0;
    else if (low_cnt_ff != '1)
      low_cnt_ff <= LOWCNT_W'(low_cnt_ff + 1'b1);
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RESET);

  property p_start_hold;
    (r_ff.st == SAP_IDLE && start_req) |=> (r_ff.st == SAP_CONV && HOLD && !BUSY_N);
  endproperty
  a_start_hold: assert property (p_start_hold)
    else $error("start request did not begin a conversion");

  property p_no_restart;
    (r_ff.st == SAP_CONV && r_ff.tick != BIT_LAST) |=> ($stable(r_ff.mask) && !BUSY_N);
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("conversion restarted or mask moved early");

  property p_busy_after_latch;
    $rose(BUSY_N) |-> ($past(lat_fire) && r_ff.word == $past(lat_if.data));
  endproperty
  a_busy_after_latch: assert property (p_busy_after_latch)
    else $error("busy rose before the output latch was loaded");

  property p_busy_on_select;
    ($fell(CS_N) && !READ_CONV_N && r_ff.st == SAP_IDLE)
      |-> ##[1:4] !BUSY_N;
  endproperty
  a_busy_on_select: assert property (p_busy_on_select)
    else $error("busy did not fall after chip select start");

  property p_hiz;
    (!rc_s || cs_s) |=> (DATA_OE == '0);
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("data driven while deselected or converting");

  property p_enable;
    (!cs_s && rc_s) |=> (DATA_OE == '1);
  endproperty
  a_enable: assert property (p_enable)
    else $error("data not enabled on read access");

  property p_lanes;
    (r_ff.st != SAP_COMMIT) ##1 1
      |-> DATA_OUT == ($past(byte_s) ? sap_swap(r_ff.word) : r_ff.word);
  endproperty
  a_lanes: assert property (p_lanes)
    else $error("byte lanes do not match byte select");

  property p_sar_clear;
    (r_ff.st == SAP_IDLE && start_req) |=> (r_ff.approx_result_reg == '0 && r_ff.mask == MSB_MASK);
  endproperty
  a_sar_clear: assert property (p_sar_clear)
    else $error("approximation register not cleared at start");

  property p_conv_len;
    $rose(BUSY_N) |-> ($past(low_cnt_ff) >= LOWCNT_W'(CONV_LAST));
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion shorter than the internal timing");

  property p_coding;
    cnv_if.valid |-> (cnv_if.data[RES_BITS-1] == (r_ff.approx_result_reg[RES_BITS-1] ^ BIPOLAR));
  endproperty
  a_coding: assert property (p_coding)
    else $error("result coding does not match variant");

  property p_busy_low;
    (r_ff.st != SAP_IDLE) |-> !BUSY_N;
  endproperty
  a_busy_low: assert property (p_busy_low)
    else $error("busy high while a conversion is pending");

  property p_rc_start;
    (r_ff.st == SAP_IDLE && !cs_s && $fell(rc_s)) |=> (HOLD && !BUSY_N);
  endproperty
  a_rc_start: assert property (p_rc_start)
    else $error("read/convert falling did not start a conversion");

  property p_push_done;
    (r_ff.st == SAP_PUSH) |-> (r_ff.mask == '0 && !HOLD);
  endproperty
  a_push_done: assert property (p_push_done)
    else $error("result pushed before the last bit was resolved");

  property p_cv_done;
    $rose(BUSY_N);
  endproperty
  c_cv_done: cover property (p_cv_done);

  property p_cv_restart;
    $rose(BUSY_N) ##1 !BUSY_N;
  endproperty
  c_cv_restart: cover property (p_cv_restart);

  property p_cv_swap_read;
    (DATA_OE == '1) && byte_s;
  endproperty
  c_cv_swap_read: cover property (p_cv_swap_read);

  property p_cv_read_commit;
    (r_ff.st == SAP_COMMIT) && oe_now;
  endproperty
  c_cv_read_commit: cover property (p_cv_read_commit);
endmodule : sap_port

// File: include/sap_pkg.sv
// Purpose: Shared constants, types and helpers of the sampling converter port
// Assumes: 250 MHz system clock
// Notes:   Conversion timing derived from the typical conversion time
package sap_pkg;
  localparam int RES_BITS     = 16;
  localparam int BYTE_BITS    = 8;
  localparam int CLK_MHZ      = 250;
  localparam int CONV_TIME_US = 7;
  localparam int CONV_CYC     = CONV_TIME_US * CLK_MHZ;
  localparam int BIT_CYC      = CONV_CYC / RES_BITS;
  localparam int TICK_W       = 7;
  localparam int BUF_DEPTH    = 2;
  localparam int SYNC_W       = 4;
  localparam int LOWCNT_W     = 12;

  localparam logic [TICK_W-1:0]   BIT_LAST = TICK_W'(BIT_CYC - 1);
  localparam logic [RES_BITS-1:0] MSB_MASK = 16'h8000;
  localparam logic [RES_BITS-1:0] WORD_RST = 16'h0000;
  // Sync order {comp, byte, read/convert, chip select}; chip select and read/convert idle high, comp and byte low
  localparam logic [SYNC_W-1:0]   SYNC_RST = 4'h3;

  typedef enum logic [1:0] {
    SAP_IDLE   = 2'b00,
    SAP_CONV   = 2'b01,
    SAP_PUSH   = 2'b11,
    SAP_COMMIT = 2'b10
  } sap_state_t;

  function automatic logic [RES_BITS-1:0] sap_swap(input logic [RES_BITS-1:0] w);
    logic [BYTE_BITS-1:0] upper_data_lanes;
    logic [BYTE_BITS-1:0] lower_data_lanes;
    upper_data_lanes = w[BYTE_BITS-1:0];
    lower_data_lanes = w[RES_BITS-1:BYTE_BITS];
    return {upper_data_lanes, lower_data_lanes};
  endfunction : sap_swap

  function automatic logic [RES_BITS-1:0] sap_code(input logic bipolar,
                                                   input logic [RES_BITS-1:0] w);
    return bipolar ? {~w[RES_BITS-1], w[RES_BITS-2:0]} : w;
  endfunction : sap_code
endpackage : sap_pkg

// File: include/sap_stream_if.sv
// Purpose: Valid/ready word channel between converter, buffer and latch
// Assumes: Single clock domain
// Notes:   Transfer when valid and ready are both high at a clock edge
`timescale 1ns/1ps
interface sap_stream_if #(parameter int W = 16) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface : sap_stream_if

// File: logic/sap_sync.sv
// Purpose: Two-flop synchroniser for asynchronous pin inputs
// Assumes: Inputs may change at any time relative to clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module sap_sync #(
  parameter int              W       = 4,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sap_sync_t;

  sap_sync_t r_ff;
  sap_sync_t nxt_r;

  always_comb
  begin
    nxt_r    = r_ff;
    nxt_r.s1 = din;
    nxt_r.s2 = r_ff.s1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      r_ff <= {RST_VAL, RST_VAL};
    else
      r_ff <= nxt_r;
  end

  assign dout = r_ff.s2;
endmodule : sap_sync

// File: logic/sap_buf2.sv
// Purpose: Small result buffer with valid/ready on both sides
// Assumes: DEPTH of at least two
// Notes:   Full and empty are exact; a stalled drain fills it
`timescale 1ns/1ps
module sap_buf2
  import sap_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH,
  parameter int W     = RES_BITS
) (
  input  wire logic    clk,
  input  wire logic    rst,
  sap_stream_if.sink   in_if,
  sap_stream_if.source out_if
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [CW-1:0]           cnt;
  } sap_buf_t;

  sap_buf_t r_ff;
  sap_buf_t nxt_r;
  logic     push;
  logic     pop;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : ptr_inc

  always_comb
  begin
    nxt_r        = r_ff;
    in_if.ready  = (r_ff.cnt != CW'(DEPTH));
    out_if.valid = (r_ff.cnt != '0);
    out_if.data  = r_ff.mem[r_ff.rp];
    push         = in_if.valid && in_if.ready;
    pop          = out_if.valid && out_if.ready;
    if (push)
    begin
      nxt_r.mem[r_ff.wp] = in_if.data;
      nxt_r.wp           = ptr_inc(r_ff.wp);
    end
    if (pop)
      nxt_r.rp = ptr_inc(r_ff.rp);
    if (push && !pop)
      nxt_r.cnt = CW'(r_ff.cnt + 1'b1);
    else if (pop && !push)
      nxt_r.cnt = CW'(r_ff.cnt - 1'b1);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      r_ff <= '0;
    else
      r_ff <= nxt_r;
  end
endmodule : sap_buf2

// File: testbench/sap_host_model.sv
// Purpose: Host on the parallel port: pin sequencing and busy polling
// Assumes: Pins move 1ns after a rising edge; 4ns clock
// Notes:   Never drives the data lanes; caller checks them
`timescale 1ns/1ps
module sap_host_model (
  input  wire logic clk,
  input  wire logic busy_n,
  output logic      cs_n,
  output logic      rc_n,
  output logic      byte_sel
);
  initial
  begin
    cs_n     = 1'b1;
    rc_n     = 1'b1;
    byte_sel = 1'b0;
  end

  task automatic pins(input logic cs, input logic rc, input logic bs, input int cyc);
    @(posedge clk);
    #1;
    cs_n     = cs;
    rc_n     = rc;
    byte_sel = bs;
    repeat (cyc) @(posedge clk);
    #2;
  endtask : pins

  task automatic start_rc();
    pins(1'b0, 1'b0, byte_sel, 10);
    pins(1'b0, 1'b1, byte_sel, 0);
  endtask : start_rc

  task automatic start_cs();
    pins(1'b1, 1'b0, byte_sel, 3);
    pins(1'b0, 1'b0, byte_sel, 10);
    pins(1'b1, 1'b0, byte_sel, 2);
    pins(1'b1, 1'b1, byte_sel, 0);
  endtask : start_cs

  task automatic wait_high(input int max, output int n);
    n = 0;
    while (busy_n !== 1'b1 && n < max)
    begin
      @(posedge clk);
      #2;
      n++;
    end
  endtask : wait_high
endmodule : sap_host_model

// File: testbench/sap_port_tb_top.sv
// Purpose: Self-checking bench of the converter control and result port
// Assumes: Comparator model keeps bits while trial code is not above target
// Notes:   Inputs move 1ns after the rising edge
`timescale 1ns/1ps
module sap_port_tb_top;
  logic        clk_sys;
  logic        reset;
  logic        cs_n;
  logic        rc_n;
  logic        byte_sel;
  logic        busy_n;
  logic        hold;
  logic [15:0] dac_code;
  logic [15:0] data_out;
  logic [15:0] data_oe;
  logic [15:0] target;
  int          error_cnt;
  int          compares;
  int          cyc;

  sap_port u_sap_port (
    .CLK_SYS     (clk_sys),
    .RESET       (reset),
    .CS_N        (cs_n),
    .READ_CONV_N (rc_n),
    .BYTE_SEL    (byte_sel),
    .COMP_IN     (dac_code <= target),
    .BUSY_N      (busy_n),
    .HOLD        (hold),
    .DAC_CODE    (dac_code),
    .DATA_OUT    (data_out),
    .DATA_OE     (data_oe)
  );

  sap_host_model u_host (
    .clk      (clk_sys),
    .busy_n   (busy_n),
    .cs_n     (cs_n),
    .rc_n     (rc_n),
    .byte_sel (byte_sel)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) cyc <= cyc + 1;

  task automatic tally_and_finish();
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic t_mode1();
    int t0;
    int n;
    target = 16'hA53C;
    u_host.pins(1'b0, 1'b1, 1'b0, 5);
    t0 = cyc;
    u_host.start_rc();
    chk(16'(busy_n), 16'h0000);
    chk(16'(hold), 16'h0001);
    u_host.pins(1'b0, 1'b1, 1'b0, 400);
    u_host.pins(1'b0, 1'b0, 1'b0, 8);
    chk(data_oe, 16'h0000);
    u_host.pins(1'b0, 1'b1, 1'b0, 0);
    u_host.wait_high(2000, n);
    chk(16'((cyc - t0) inside {[1745:1765]}), 16'h0001);
    u_host.pins(1'b0, 1'b1, 1'b0, 1);
    chk(16'(hold), 16'h0000);
    chk(data_oe, 16'hFFFF);
    chk(data_out, 16'hA53C);
    u_host.pins(1'b0, 1'b1, 1'b1, 4);
    chk(data_out, 16'h3CA5);
    u_host.pins(1'b1, 1'b1, 1'b0, 4);
    chk(data_oe, 16'h0000);
  endtask : t_mode1

  task automatic t_mode2();
    int t0;
    int n;
    target = 16'h5AC3;
    t0 = cyc;
    u_host.start_cs();
    chk(16'(busy_n), 16'h0000);
    u_host.pins(1'b1, 1'b1, 1'b0, 4);
    chk(data_oe, 16'h0000);
    u_host.wait_high(2000, n);
    chk(16'((cyc - t0) inside {[1745:1770]}), 16'h0001);
    chk(data_oe, 16'h0000);
    u_host.pins(1'b0, 1'b1, 1'b0, 4);
    chk(data_oe, 16'hFFFF);
    chk(data_out, 16'h5AC3);
    u_host.pins(1'b0, 1'b1, 1'b1, 4);
    chk(data_out, 16'hC35A);
    u_host.pins(1'b1, 1'b1, 1'b0, 4);
  endtask : t_mode2

  task automatic t_restart();
    int n;
    target = 16'h0001;
    u_host.pins(1'b0, 1'b0, 1'b0, 4);
    chk(16'(busy_n), 16'h0000);
    u_host.wait_high(2000, n);
    chk(16'(busy_n), 16'h0001);
    u_host.pins(1'b0, 1'b0, 1'b0, 4);
    chk(16'(busy_n), 16'h0000);
    u_host.pins(1'b1, 1'b1, 1'b0, 0);
    u_host.wait_high(2000, n);
    chk(16'(busy_n), 16'h0001);
  endtask : t_restart

  initial
  begin
    reset     = 1'b1;
    target    = 16'h0000;
    error_cnt = 0;
    compares  = 0;
    repeat (5) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    repeat (2) @(posedge clk_sys);
    #2;
    chk(16'(busy_n), 16'h0001);
    chk(data_oe, 16'h0000);
    t_mode1();
    t_mode2();
    t_restart();
    tally_and_finish();
  end

  initial
  begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end
endmodule : sap_port_tb_top
